// ---- rtl/tdrf_cfg.svh ----
// constants for the tlb debug readout formatter
`ifndef TDRF_CFG_SVH
`define TDRF_CFG_SVH
// register byte offsets
`define TDRF_OFF_SEL 8'h00
`define TDRF_OFF_CTRL 8'h04
`define TDRF_OFF_DATA 8'h08
`define TDRF_OFF_STAT 8'h0C
// word 4 fields
`define TDRF_W4_NS_HI 31
`define TDRF_W4_NS_LO 30
`define TDRF_W4_SH_HI 29
`define TDRF_W4_SH_LO 27
`define TDRF_W4_IRA_HI 26
`define TDRF_W4_IRA_LO 25
`define TDRF_W4_ORA_HI 24
`define TDRF_W4_ORA_LO 23
`define TDRF_W4_IWA_HI 22
`define TDRF_W4_IWA_LO 21
`define TDRF_W4_OWA_HI 20
`define TDRF_W4_OWA_LO 19
`define TDRF_W4_PXN 18
`define TDRF_W4_XN2 17
`define TDRF_W4_XN1 16
`define TDRF_W4_P2_HI 12
`define TDRF_W4_P2_LO 11
`define TDRF_W4_P1_HI 10
`define TDRF_W4_P1_LO 8
`define TDRF_W4_PRIV_HI 7
`define TDRF_W4_PRIV_LO 6
`define TDRF_W4_INST_HI 5
`define TDRF_W4_INST_LO 4
// word 5 fields
`define TDRF_W5_MSKH_HI 25
`define TDRF_W5_MSKH_LO 20
`define TDRF_W5_IDH_HI 19
`define TDRF_W5_IDH_LO 14
`define TDRF_W5_PAR 13
`define TDRF_W5_ITR_HI 12
`define TDRF_W5_ITR_LO 11
`define TDRF_W5_OTR_HI 10
`define TDRF_W5_OTR_LO 9
`define TDRF_W5_ATTR_HI 8
`define TDRF_W5_ATTR_LO 4
// word 6 fields
`define TDRF_W6_MSK_HI 23
`define TDRF_W6_MSK_LO 14
`define TDRF_W6_ID_HI 13
`define TDRF_W6_ID_LO 4
// common trailer
`define TDRF_TR_VAL_HI 3
`define TDRF_TR_VAL_LO 2
`define TDRF_TR_PTR 1
`define TDRF_TR_INFO 0
// selector and control reset values, narrow identifier width
`define TDRF_SEL_RST 2'h0
`define TDRF_CTRL_RST 1'h1
`define TDRF_SID_NARROW 10
`endif

// ---- rtl/tdrf_pkg.sv ----
// types for the tlb debug readout formatter
`default_nettype none
package tdrf_pkg;
	// which debug word is selected
	typedef enum logic [1:0] {
		TDRF_WORD4 = 2'b00,
		TDRF_WORD5 = 2'b01,
		TDRF_WORD6 = 2'b10
	} tdrf_word_type;
	// bus slave states
	typedef enum logic [0:0] {
		TDRF_IDLE = 1'b0,
		TDRF_ACK = 1'b1
	} tdrf_bus_type;
endpackage
`default_nettype wire

// ---- rtl/tdrf_format.sv ----
// packs one tlb entry into debug words 4, 5 and 6
`include "tdrf_cfg.svh"
`default_nettype none
module tdrf_format
	import tdrf_pkg::*;
#(
	parameter int SID_W = 16
) (
	input wire logic [1:0] nonsecure_setting,
	input wire logic [2:0] shareability_setting,
	input wire logic [1:0] read_alloc_hint_in,
	input wire logic [1:0] read_alloc_hint_out,
	input wire logic [1:0] write_alloc_hint_in,
	input wire logic [1:0] write_alloc_hint_out,
	input wire logic priv_exec_never,
	input wire logic exec_never_flag_s2,
	input wire logic exec_never_flag_s1,
	input wire logic [1:0] stage2_permissions,
	input wire logic [2:0] stage1_permissions,
	input wire logic [1:0] privilege_setting,
	input wire logic [1:0] instruction_setting,
	input wire logic parity_bit,
	input wire logic [1:0] transient_hint_in,
	input wire logic [1:0] transient_hint_out,
	input wire logic [4:0] mem_attr,
	input wire logic [4:0] mem_attr_overlay,
	input wire logic context_translate_enable,
	input wire logic [SID_W-1:0] stream_identifier,
	input wire logic [SID_W-1:0] stream_mask,
	input wire logic [1:0] entry_validity_state,
	input wire logic pointer_valid_flag,
	input wire logic word_info_flag,
	input wire tdrf_word_type word_sel,
	output logic [31:0] word
);
	logic [5:0] sid_hi; // identifier bits 15:10 or zero
	logic [5:0] msk_hi; // mask bits 15:10 or zero
	logic [15:0] sid_x; // identifier widened to 16
	logic [15:0] msk_x; // mask widened to 16
	// widen identifier and mask, upper bits only when configured wide
	always_comb begin
		sid_x = 16'h0000;
		msk_x = 16'h0000;
		sid_x[SID_W-1:0] = stream_identifier;
		msk_x[SID_W-1:0] = stream_mask;
		sid_hi = (SID_W > `TDRF_SID_NARROW) ? sid_x[15:10] : 6'h00;
		msk_hi = (SID_W > `TDRF_SID_NARROW) ? msk_x[15:10] : 6'h00;
	end
	// build the selected word; reserved bits stay zero
	always_comb begin
		word = 32'h0000_0000;
		case (word_sel)
			TDRF_WORD4: begin
				word[`TDRF_W4_NS_HI:`TDRF_W4_NS_LO] = nonsecure_setting;
				word[`TDRF_W4_SH_HI:`TDRF_W4_SH_LO] = shareability_setting;
				word[`TDRF_W4_IRA_HI:`TDRF_W4_IRA_LO] = read_alloc_hint_in;
				word[`TDRF_W4_ORA_HI:`TDRF_W4_ORA_LO] = read_alloc_hint_out;
				word[`TDRF_W4_IWA_HI:`TDRF_W4_IWA_LO] = write_alloc_hint_in;
				word[`TDRF_W4_OWA_HI:`TDRF_W4_OWA_LO] = write_alloc_hint_out;
				word[`TDRF_W4_PXN] = priv_exec_never;
				word[`TDRF_W4_XN2] = exec_never_flag_s2;
				word[`TDRF_W4_XN1] = exec_never_flag_s1;
				word[`TDRF_W4_P2_HI:`TDRF_W4_P2_LO] = stage2_permissions;
				word[`TDRF_W4_P1_HI:`TDRF_W4_P1_LO] = stage1_permissions;
				word[`TDRF_W4_PRIV_HI:`TDRF_W4_PRIV_LO] = privilege_setting;
				word[`TDRF_W4_INST_HI:`TDRF_W4_INST_LO] =
					instruction_setting;
			end
			TDRF_WORD5: begin
				word[`TDRF_W5_MSKH_HI:`TDRF_W5_MSKH_LO] = msk_hi;
				word[`TDRF_W5_IDH_HI:`TDRF_W5_IDH_LO] = sid_hi;
				word[`TDRF_W5_PAR] = parity_bit;
				word[`TDRF_W5_ITR_HI:`TDRF_W5_ITR_LO] = transient_hint_in;
				word[`TDRF_W5_OTR_HI:`TDRF_W5_OTR_LO] = transient_hint_out;
				// overlay applies while translation is off
				word[`TDRF_W5_ATTR_HI:`TDRF_W5_ATTR_LO] =
					context_translate_enable ? mem_attr : mem_attr_overlay;
			end
			TDRF_WORD6: begin
				word[`TDRF_W6_MSK_HI:`TDRF_W6_MSK_LO] = msk_x[9:0];
				word[`TDRF_W6_ID_HI:`TDRF_W6_ID_LO] = sid_x[9:0];
			end
			default: begin
				word = 32'h0000_0000; // unmapped selector reads zero
			end
		endcase
		// common trailer on every mapped word
		if (word_sel != 2'b11) begin
			word[`TDRF_TR_VAL_HI:`TDRF_TR_VAL_LO] = entry_validity_state;
			word[`TDRF_TR_PTR] = pointer_valid_flag;
			word[`TDRF_TR_INFO] = word_info_flag;
		end
	end
endmodule // tdrf_format
`default_nettype wire

// ---- rtl/tdrf_top.sv ----
// tlb debug readout formatter with wishbone register slave
//
// Register access over Wishbone and the register offsets were decided locally.
`include "tdrf_cfg.svh"
`default_nettype none
module tdrf_top
	import tdrf_pkg::*;
#(
	parameter int SID_W = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// tlb entry fields from the lookup
	input wire logic [1:0] nonsecure_setting,
	input wire logic [2:0] shareability_setting,
	input wire logic [1:0] read_alloc_hint_in,
	input wire logic [1:0] read_alloc_hint_out,
	input wire logic [1:0] write_alloc_hint_in,
	input wire logic [1:0] write_alloc_hint_out,
	input wire logic priv_exec_never,
	input wire logic exec_never_flag_s2,
	input wire logic exec_never_flag_s1,
	input wire logic [1:0] stage2_permissions,
	input wire logic [2:0] stage1_permissions,
	input wire logic [1:0] privilege_setting,
	input wire logic [1:0] instruction_setting,
	input wire logic parity_bit,
	input wire logic [1:0] transient_hint_in,
	input wire logic [1:0] transient_hint_out,
	input wire logic [4:0] mem_attr,
	input wire logic [4:0] mem_attr_overlay,
	input wire logic [SID_W-1:0] stream_identifier,
	input wire logic [SID_W-1:0] stream_mask,
	input wire logic [1:0] entry_validity_state,
	input wire logic pointer_valid_flag,
	input wire logic word_info_flag
);
	// refuse identifier widths the word layout cannot hold
	initial begin
		if (SID_W < 1 || SID_W > 16) begin
			$error("tdrf_top: SID_W must be 1 to 16");
		end
	end

	tdrf_bus_type bus_r; // slave state
	logic [1:0] sel_r; // word selector register
	logic xlat_en_r; // context translate enable
	logic [31:0] word; // formatted word, combinational
	logic req; // new request this cycle

	assign req = wb_cyc_i && wb_stb_i && (bus_r == TDRF_IDLE);

	// formatter instance
	tdrf_format #(
		.SID_W(SID_W)
	) u_fmt (
		.nonsecure_setting(nonsecure_setting),
		.shareability_setting(shareability_setting),
		.read_alloc_hint_in(read_alloc_hint_in),
		.read_alloc_hint_out(read_alloc_hint_out),
		.write_alloc_hint_in(write_alloc_hint_in),
		.write_alloc_hint_out(write_alloc_hint_out),
		.priv_exec_never(priv_exec_never),
		.exec_never_flag_s2(exec_never_flag_s2),
		.exec_never_flag_s1(exec_never_flag_s1),
		.stage2_permissions(stage2_permissions),
		.stage1_permissions(stage1_permissions),
		.privilege_setting(privilege_setting),
		.instruction_setting(instruction_setting),
		.parity_bit(parity_bit),
		.transient_hint_in(transient_hint_in),
		.transient_hint_out(transient_hint_out),
		.mem_attr(mem_attr),
		.mem_attr_overlay(mem_attr_overlay),
		.context_translate_enable(xlat_en_r),
		.stream_identifier(stream_identifier),
		.stream_mask(stream_mask),
		.entry_validity_state(entry_validity_state),
		.pointer_valid_flag(pointer_valid_flag),
		.word_info_flag(word_info_flag),
		.word_sel(tdrf_word_type'(sel_r)),
		.word(word)
	);

	// ack for one cycle per request, then drop
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bus_r <= TDRF_IDLE;
			wb_ack_o <= 1'b0;
		end else begin
			case (bus_r)
				TDRF_IDLE: begin
					wb_ack_o <= req;
					bus_r <= req ? TDRF_ACK : TDRF_IDLE;
				end
				TDRF_ACK: begin
					wb_ack_o <= 1'b0;
					bus_r <= TDRF_IDLE;
				end
				default: begin
					wb_ack_o <= 1'b0;
					bus_r <= TDRF_IDLE;
				end
			endcase
		end
	end

	// writable control registers, lane 0 only
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sel_r <= `TDRF_SEL_RST;
			xlat_en_r <= `TDRF_CTRL_RST;
		end else if (req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == `TDRF_OFF_SEL) begin
				sel_r <= wb_dat_i[1:0];
			end
			if (wb_adr_i == `TDRF_OFF_CTRL) begin
				xlat_en_r <= wb_dat_i[0];
			end
		end
	end

	// read data captured with the ack; unmapped reads zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			case (wb_adr_i)
				`TDRF_OFF_SEL: wb_dat_o <= {30'h0, sel_r};
				`TDRF_OFF_CTRL: wb_dat_o <= {31'h0, xlat_en_r};
				`TDRF_OFF_DATA: wb_dat_o <= word;
				`TDRF_OFF_STAT: wb_dat_o <= {29'h0, entry_validity_state,
					pointer_valid_flag};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// assertions
	logic rd_data; // data read accepted
	assign rd_data = req && !wb_we_i && wb_adr_i == `TDRF_OFF_DATA;

	property p_ack_one;
		@(posedge ref_clk) disable iff (!nrst)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");

	property p_trailer;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r != 2'b11 |=> wb_dat_o[3:0] ==
			$past({entry_validity_state, pointer_valid_flag, word_info_flag});
	endproperty
	a_trailer: assert property (p_trailer) else $error("bad trailer");

	property p_w4_res;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b00 |=> wb_dat_o[15:13] == 3'h0 &&
			wb_dat_o[31:30] == $past(nonsecure_setting);
	endproperty
	a_w4_res: assert property (p_w4_res) else $error("word4 bad");

	property p_w4_xn;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b00 |=> wb_dat_o[18:16] ==
			$past({priv_exec_never, exec_never_flag_s2, exec_never_flag_s1});
	endproperty
	a_w4_xn: assert property (p_w4_xn) else $error("xn bad");

	property p_w5_attr;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b01 && !xlat_en_r |=>
			wb_dat_o[8:4] == $past(mem_attr_overlay) &&
			wb_dat_o[31:26] == 6'h00;
	endproperty
	a_w5_attr: assert property (p_w5_attr) else $error("attr bad");

	property p_w5_par;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b01 |=> wb_dat_o[13] == $past(parity_bit);
	endproperty
	a_w5_par: assert property (p_w5_par) else $error("parity bad");

	property p_w6;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b10 |=> wb_dat_o[31:24] == 8'h00 &&
			wb_dat_o[13:4] == $past(stream_identifier[9:0]);
	endproperty
	a_w6: assert property (p_w6) else $error("word6 bad");

	property p_w4_perm;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b00 |=> wb_dat_o[12:8] ==
			$past({stage2_permissions, stage1_permissions});
	endproperty
	a_w4_perm: assert property (p_w4_perm) else $error("perm bad");

	property p_w4_ra;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && sel_r == 2'b00 |=> wb_dat_o[26:23] ==
			$past({read_alloc_hint_in, read_alloc_hint_out});
	endproperty
	a_w4_ra: assert property (p_w4_ra) else $error("alloc bad");
endmodule // tdrf_top
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the tlb debug readout formatter
`include "tdrf_cfg.svh"
`default_nettype none
module tb_top
	import tdrf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0; // 40 mhz clock
	logic nrst = 1'b0; // active low reset
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
	logic [7:0] adr = 8'h00; // byte address
	logic [3:0] sel = 4'h0; // byte lanes
	logic [31:0] wdat = 32'h0; // write data
	logic [31:0] rdat; // read data from slave
	logic ack; // slave answer
	logic [75:0] ent = 76'h0; // packed entry fields
	logic [31:0] q; // last read result
	int bad_count = 0; // mismatches
	int samples_checked = 0; // comparisons
	int cycles = 0; // timeout counter
	// tables of entry patterns
	// last entry gives neighbouring fields different values
	logic [75:0] pats [5] = '{76'h0, {76{1'b1}},
		76'hAAA_AAAA_AAAA_AAAA_AAAA, 76'h555_5555_5555_5555_5555,
		76'h9C6_3E1B_2D47_A58F_0F96};

	always #12.5 ref_clk = ~ref_clk; // 25 ns period

	tdrf_top #(.SID_W(16)) dut_u (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(wdat),
		.wb_dat_o(rdat),
		.wb_ack_o(ack),
		.nonsecure_setting(ent[1:0]),
		.shareability_setting(ent[4:2]),
		.read_alloc_hint_in(ent[6:5]),
		.read_alloc_hint_out(ent[8:7]),
		.write_alloc_hint_in(ent[10:9]),
		.write_alloc_hint_out(ent[12:11]),
		.priv_exec_never(ent[13]),
		.exec_never_flag_s2(ent[14]),
		.exec_never_flag_s1(ent[15]),
		.stage2_permissions(ent[17:16]),
		.stage1_permissions(ent[20:18]),
		.privilege_setting(ent[22:21]),
		.instruction_setting(ent[24:23]),
		.parity_bit(ent[25]),
		.transient_hint_in(ent[27:26]),
		.transient_hint_out(ent[29:28]),
		.mem_attr(ent[34:30]),
		.mem_attr_overlay(ent[39:35]),
		.stream_identifier(ent[55:40]),
		.stream_mask(ent[71:56]),
		.entry_validity_state(ent[73:72]),
		.pointer_valid_flag(ent[74]),
		.word_info_flag(ent[75])
	);

	// expected debug word for an entry, selector and translate enable
	function automatic logic [31:0] exp_word(logic [75:0] e, int w,
		logic te);
		logic [3:0] tr;
		tr = {e[73:72], e[74], e[75]};
		case (w)
			0: return {e[1:0], e[4:2], e[6:5], e[8:7], e[10:9], e[12:11],
				e[13], e[14], e[15], 3'h0, e[17:16], e[20:18], e[22:21],
				e[24:23], tr};
			1: return {6'h00, e[71:66], e[55:50], e[25], e[27:26],
				e[29:28], te ? e[34:30] : e[39:35], tr};
			2: return {8'h00, e[65:56], e[49:40], tr};
			default: return 32'h0;
		endcase
	endfunction

	// one classic bus cycle, held until ack is seen
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		// ack is sampled at the rising edge, request held until then
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			$display("mismatch ack expected 1 seen timeout");
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(negedge ref_clk);
		chk("ack_drop", 32'h0, {31'h0, ack});
	endtask

	// compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// compare one whole debug word, named by selected word, then its trailer
	task automatic chk_word(input logic [75:0] e, input int w,
		input logic te, input logic [31:0] g);
		logic [31:0] x;
		x = exp_word(e, w, te);
		case (w)
			0: chk("word4", x, g);
			1: chk("word5", x, g);
			2: chk("word6", x, g);
			default: chk("word_none", x, g);
		endcase
		chk("trailer", {28'h0, x[3:0]}, {28'h0, g[3:0]});
	endtask

	// print counts and verdict, then stop
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// cuts a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			results();
		end
	end

	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(negedge ref_clk);
		chk("ack_reset", 32'h0, {31'h0, ack});
		chk("dat_reset", 32'h0, rdat);
		xfer(1'b0, `TDRF_OFF_SEL, 32'h0, q);
		chk("sel_reset", 32'h0, q);
		xfer(1'b0, `TDRF_OFF_CTRL, 32'h0, q);
		chk("ctrl_reset", 32'h1, q);
		$display("test reset done");
		for (int m = 1; m >= 0; m--) begin
			xfer(1'b1, `TDRF_OFF_CTRL, m, q);
			for (int p = 0; p < 5; p++) begin
				@(posedge ref_clk);
				ent <= pats[p];
				for (int w = 0; w < 4; w++) begin
					xfer(1'b1, `TDRF_OFF_SEL, w, q);
					xfer(1'b0, `TDRF_OFF_DATA, 32'h0, q);
					chk_word(pats[p], w, m[0], q);
				end
			end
			$display("test word formats done");
		end
		// read-only data place ignores a write
		xfer(1'b1, `TDRF_OFF_SEL, 32'h2, q);
		xfer(1'b1, `TDRF_OFF_DATA, 32'hFFFF_FFFF, q);
		xfer(1'b0, `TDRF_OFF_DATA, 32'h0, q);
		chk("data_ro", exp_word(pats[4], 2, 1'b0), q);
		xfer(1'b0, `TDRF_OFF_STAT, 32'h0, q);
		chk("status", {29'h0, pats[4][73:72], pats[4][74]}, q);
		xfer(1'b0, 8'h10, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("test access kinds done");
		results();
	end
endmodule // tb_top
`default_nettype wire
